/* verilog/acb_pkg.sv */
// Constants for the compare, clear, complement, decimal adjust, decrement and divide unit
package acb_pkg;
  localparam logic [7:0] OP_CMP_DIR = 8'hB5;
  localparam logic [7:0] OP_CMP_IMM = 8'hB4;
  localparam logic [6:0] OP_CMP_IND = 7'h5B;
  localparam logic [4:0] OP_CMP_REG = 5'h17;
  localparam logic [7:0] OP_ZERO_A = 8'hE4;
  localparam logic [7:0] OP_ZERO_C = 8'hC3;
  localparam logic [7:0] OP_ZERO_BIT = 8'hC2;
  localparam logic [7:0] OP_INV_A = 8'hF4;
  localparam logic [7:0] OP_INV_C = 8'hB3;
  localparam logic [7:0] OP_INV_BIT = 8'hB2;
  localparam logic [7:0] OP_BCD_ADJ = 8'hD4;
  localparam logic [7:0] OP_DEC_A = 8'h14;
  localparam logic [7:0] OP_DEC_DIR = 8'h15;
  localparam logic [6:0] OP_DEC_IND = 7'h0B;
  localparam logic [4:0] OP_DEC_REG = 5'h03;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [3:0] NIB_NINE = 4'h9;
  localparam logic [7:0] ADJ_LOW = 8'h06;
  localparam logic [7:0] ADJ_HIGH = 8'h60;
  localparam logic [2:0] CYC_CMP = 3'h2;
  localparam logic [2:0] CYC_DIV = 3'h4;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [1:0] LEN_CMP = 2'h3;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] B_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  typedef enum logic [3:0] {
    ACB_IDLE = 4'b0001,
    ACB_EXEC = 4'b0010,
    ACB_WAIT = 4'b0100,
    ACB_DONE = 4'b1000
  } acb_state_e;
endpackage

/* verilog/acb_divider.sv */
// Restoring 8-bit unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
module acb_divider
  import acb_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic [WIDTH-1:0] dividend_in,
  input wire logic [WIDTH-1:0] divisor_in,
  output logic done_out,
  output logic [WIDTH-1:0] quotient_out,
  output logic [WIDTH-1:0] remainder_out
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [$clog2(WIDTH+1)-1:0] cnt;
    logic [WIDTH-1:0] quo;
    logic [WIDTH-1:0] rem;
    logic [WIDTH-1:0] dvs;
  } acb_div_s;

  acb_div_s st_r;
  acb_div_s st_nxt;

  always_comb begin
    logic [WIDTH:0] trial;
    trial = '0;
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start_in) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt = '0;
      st_nxt.quo = dividend_in;
      st_nxt.rem = '0;
      st_nxt.dvs = divisor_in;
    end else if (st_r.busy) begin
      trial = {st_r.rem, st_r.quo[WIDTH-1]} - {1'b0, st_r.dvs};
      if (!trial[WIDTH]) begin
        st_nxt.rem = trial[WIDTH-1:0];
        st_nxt.quo = {st_r.quo[WIDTH-2:0], 1'b1};
      end else begin
        st_nxt.rem = {st_r.rem[WIDTH-2:0], st_r.quo[WIDTH-1]};
        st_nxt.quo = {st_r.quo[WIDTH-2:0], 1'b0};
      end
      st_nxt.cnt = st_r.cnt + 1'b1;
      if (st_r.cnt == ($clog2(WIDTH+1))'(WIDTH - 1)) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done_out = st_r.done;
  assign quotient_out = st_r.quo;
  assign remainder_out = st_r.rem;
endmodule // acb_divider

/* verilog/acb_alu_ops.sv */
// Execution unit for compare-branch, clear, complement, decimal adjust, decrement and divide
//
// Contract
// RULE_01 - Compare-branch is 3 bytes, 2 cycles; PC+3, then add displacement if unequal
// RULE_02 - Compare-branch sets carry when destination below source; operands untouched
// RULE_03 - Compare-branch pairs: A/direct, A/immediate, working register/imm, indirect/imm
// RULE_04 - Opcode B5 decodes A versus direct byte, then displacement byte
// RULE_05 - Opcode B4 is A versus immediate; 1011011i is indirect versus immediate
// RULE_06 - Opcode E4 zeroes the accumulator, flags unchanged
// RULE_07 - C3 clears carry, C2 clears an addressed bit; no other flag changes
// RULE_08 - Opcode F4 inverts all accumulator bits, flags unchanged
// RULE_09 - B3 toggles carry, B2 toggles addressed bit; no other flag changes
// RULE_10 - Bit toggle on a port bit reads the output latch, not the pin
// RULE_11 - Adjust adds 6 if low nibble above 9 or nibble carry; carry only set
// RULE_12 - Then add 6 to high nibble if carry or above 9; wrap flag kept
// RULE_13 - Adjust finishes in one cycle by adding 00, 06, 60 or 66
// RULE_14 - Adjust decodes from D4 and takes one cycle
// RULE_15 - Decrement wraps 00 to FF and alters no flags
// RULE_16 - Decrement targets: accumulator, working register, direct byte, indirect byte
// RULE_17 - Decrement of a port reads the output latch, not the pins
// RULE_18 - Divide A by B: quotient to A, remainder to B, clear flags, 4 cycles; code keeps op_ready_out low for 11 clocks, 8 of them in the divider
// RULE_19 - Divide by zero sets wrap flag, clears carry; results undefined
// RULE_20 - Preceding add sets nibble carry from bit 3 and carry from bit 7
`timescale 1ns/1ps
module acb_alu_ops
  import acb_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic op_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] operand1_in,
  input wire logic [7:0] operand2_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [7:0] reg_rdata_in,
  input wire logic bit_rdata_in,
  input wire logic add_valid_in,
  input wire logic [7:0] add_src_in,
  input wire logic add_with_carry_in,
  input wire logic [15:0] pc_in,
  output logic op_ready_out,
  output logic [7:0] acc_out,
  output logic [7:0] b_out,
  output logic carry_out,
  output logic nibble_carry_out,
  output logic signed_wrap_out,
  output logic [15:0] pc_out,
  output logic pc_load_out,
  output logic [2:0] reg_sel_out,
  output logic ptr_sel_out,
  output logic latch_read_out,
  output logic mem_we_out,
  output logic reg_we_out,
  output logic [7:0] wdata_out,
  output logic bit_we_out,
  output logic bit_wdata_out,
  output logic [7:0] addr_out
);
  typedef struct packed {
    acb_state_e state;
    logic [7:0] op;
    logic [7:0] opd1;
    logic [7:0] opd2;
    logic [2:0] cyc;
    logic [7:0] acc;
    logic [7:0] b;
    logic cy;
    logic ac;
    logic ov;
    logic [15:0] pc;
    logic pc_load;
    logic mem_we;
    logic reg_we;
    logic [7:0] wdata;
    logic bit_we;
    logic bit_wdata;
    logic [7:0] addr;
    logic div_zero;
  } acb_core_s;

  acb_core_s st_r;
  acb_core_s st_nxt;
  logic div_start;
  logic div_done;
  logic [7:0] div_quo;
  logic [7:0] div_rem;

  // Decode of the held opcode
  logic is_cmp_dir;
  logic is_cmp_imm;
  logic is_cmp_ind;
  logic is_cmp_reg;
  logic is_cmp;
  logic is_dec_reg;
  logic is_dec_ind;
  assign is_cmp_dir = (st_r.op == OP_CMP_DIR); // RULE_04
  assign is_cmp_imm = (st_r.op == OP_CMP_IMM); // RULE_05
  assign is_cmp_ind = (st_r.op[7:1] == OP_CMP_IND); // RULE_05
  assign is_cmp_reg = (st_r.op[7:3] == OP_CMP_REG); // RULE_03
  assign is_cmp = is_cmp_dir | is_cmp_imm | is_cmp_ind | is_cmp_reg;
  assign is_dec_reg = (st_r.op[7:3] == OP_DEC_REG);
  assign is_dec_ind = (st_r.op[7:1] == OP_DEC_IND);

  acb_divider #(
    .WIDTH(8)
  ) u_div (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .start_in(div_start),
    .dividend_in(st_r.acc),
    .divisor_in(st_r.b),
    .done_out(div_done),
    .quotient_out(div_quo),
    .remainder_out(div_rem)
  );

  always_comb begin
    logic [7:0] lhs;
    logic [7:0] rhs;
    logic [7:0] dec_src;
    logic [8:0] adj;
    logic [4:0] lo_sum;
    logic [8:0] add_sum;
    lhs = st_r.acc;
    rhs = st_r.opd1;
    dec_src = 8'h00;
    adj = 9'h000;
    lo_sum = 5'h00;
    add_sum = 9'h000;
    st_nxt = st_r;
    st_nxt.pc_load = 1'b0;
    st_nxt.mem_we = 1'b0;
    st_nxt.reg_we = 1'b0;
    st_nxt.bit_we = 1'b0;
    div_start = 1'b0;
    case (st_r.state)
      ACB_IDLE: begin
        if (op_valid_in) begin
          st_nxt.op = opcode_in;
          st_nxt.opd1 = operand1_in;
          st_nxt.opd2 = operand2_in;
          st_nxt.pc = pc_in;
          st_nxt.state = ACB_EXEC;
        end else if (add_valid_in) begin
          lo_sum = {1'b0, st_r.acc[3:0]} + {1'b0, add_src_in[3:0]}
            + {4'h0, add_with_carry_in & st_r.cy};
          add_sum = {1'b0, st_r.acc} + {1'b0, add_src_in}
            + {8'h00, add_with_carry_in & st_r.cy};
          st_nxt.ac = lo_sum[4]; // RULE_20
          st_nxt.cy = add_sum[8]; // RULE_20
          st_nxt.ov = (st_r.acc[7] == add_src_in[7]) && (add_sum[7] != st_r.acc[7]);
          st_nxt.acc = add_sum[7:0];
        end
      end
      ACB_EXEC: begin
        st_nxt.cyc = CYC_ONE;
        st_nxt.state = ACB_DONE;
        if (is_cmp) begin
          // Operands are only read, never written back
          if (is_cmp_ind) begin
            lhs = mem_rdata_in;
          end else if (is_cmp_reg) begin
            lhs = reg_rdata_in;
          end
          if (is_cmp_dir) begin
            rhs = mem_rdata_in;
          end
          st_nxt.cy = (lhs < rhs); // RULE_02
          st_nxt.pc = st_r.pc + {14'h0000, LEN_CMP}; // RULE_01
          if (lhs != rhs) begin
            st_nxt.pc = st_r.pc + {14'h0000, LEN_CMP} + {{8{st_r.opd2[7]}}, st_r.opd2}; // RULE_01
          end
          st_nxt.pc_load = 1'b1;
          st_nxt.state = ACB_WAIT; // RULE_01
        end else if (st_r.op == OP_ZERO_A) begin
          st_nxt.acc = 8'h00; // RULE_06
        end else if (st_r.op == OP_ZERO_C) begin
          st_nxt.cy = 1'b0; // RULE_07
        end else if (st_r.op == OP_ZERO_BIT) begin
          st_nxt.bit_we = 1'b1; // RULE_07
          st_nxt.bit_wdata = 1'b0;
          st_nxt.addr = st_r.opd1;
        end else if (st_r.op == OP_INV_A) begin
          st_nxt.acc = ~st_r.acc; // RULE_08
        end else if (st_r.op == OP_INV_C) begin
          st_nxt.cy = ~st_r.cy; // RULE_09
        end else if (st_r.op == OP_INV_BIT) begin
          st_nxt.bit_we = 1'b1; // RULE_09
          st_nxt.bit_wdata = ~bit_rdata_in; // RULE_10
          st_nxt.addr = st_r.opd1;
        end else if (st_r.op == OP_BCD_ADJ) begin // RULE_14
          adj = {1'b0, st_r.acc};
          if ((st_r.acc[3:0] > NIB_NINE) || st_r.ac) begin
            adj = adj + {1'b0, ADJ_LOW}; // RULE_11
          end
          if (adj[8] || st_r.cy || (adj[7:4] > NIB_NINE)) begin
            adj = {1'b0, adj[7:0]} + {1'b0, ADJ_HIGH} + {adj[8], 8'h00}; // RULE_12
          end
          st_nxt.acc = adj[7:0]; // RULE_13
          st_nxt.cy = st_r.cy | adj[8]; // RULE_11 RULE_12
        end else if (st_r.op == OP_DEC_A) begin
          st_nxt.acc = st_r.acc - 8'h01; // RULE_15
        end else if (is_dec_reg) begin
          st_nxt.reg_we = 1'b1; // RULE_16
          st_nxt.wdata = reg_rdata_in - 8'h01; // RULE_15
        end else if (st_r.op == OP_DEC_DIR || is_dec_ind) begin
          dec_src = mem_rdata_in; // RULE_17
          st_nxt.mem_we = 1'b1; // RULE_16
          st_nxt.wdata = dec_src - 8'h01; // RULE_15
          st_nxt.addr = st_r.opd1;
        end else if (st_r.op == OP_DIV) begin
          st_nxt.cy = 1'b0; // RULE_18 RULE_19
          st_nxt.div_zero = (st_r.b == 8'h00);
          st_nxt.ov = (st_r.b == 8'h00); // RULE_19
          div_start = 1'b1;
          st_nxt.state = ACB_WAIT;
        end
      end
      ACB_WAIT: begin
        st_nxt.cyc = st_r.cyc + 3'h1;
        if (is_cmp && (st_r.cyc + 3'h1 == CYC_CMP)) begin
          st_nxt.state = ACB_DONE; // RULE_01
        end else if ((st_r.op == OP_DIV) && div_done) begin
          if (!st_r.div_zero) begin
            st_nxt.acc = div_quo; // RULE_18
            st_nxt.b = div_rem; // RULE_18
          end
          // Divider needs eight clocks; hold instruction slot until results land
          st_nxt.state = ACB_DONE; // RULE_18
        end
      end
      ACB_DONE: begin
        st_nxt.state = ACB_IDLE;
      end
      default: begin
        st_nxt.state = ACB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= '{state: ACB_IDLE, acc: ACC_RST, b: B_RST, pc: PC_RST, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign op_ready_out = (st_r.state == ACB_IDLE);
  assign acc_out = st_r.acc;
  assign b_out = st_r.b;
  assign carry_out = st_r.cy;
  assign nibble_carry_out = st_r.ac;
  assign signed_wrap_out = st_r.ov;
  assign pc_out = st_r.pc;
  assign pc_load_out = st_r.pc_load;
  assign reg_sel_out = st_r.op[2:0]; // RULE_03 RULE_16
  assign ptr_sel_out = st_r.op[0];
  // Read-modify-write of port bits and bytes must see the output latch
  assign latch_read_out = (st_r.state == ACB_EXEC)
    && ((st_r.op == OP_INV_BIT) || (st_r.op == OP_DEC_DIR)); // RULE_10 RULE_17
  assign mem_we_out = st_r.mem_we;
  assign reg_we_out = st_r.reg_we;
  assign wdata_out = st_r.wdata;
  assign bit_we_out = st_r.bit_we;
  assign bit_wdata_out = st_r.bit_wdata;
  assign addr_out = st_r.addr;
endmodule // acb_alu_ops

/* verif/acb_alu_ops_chk.sv */
// Property checker for the compare, clear, complement, adjust, decrement and divide unit
`timescale 1ns/1ps
module acb_alu_ops_chk
  import acb_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic op_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] operand1_in,
  input wire logic [7:0] operand2_in,
  input wire logic [15:0] pc_in,
  input wire logic op_ready_out,
  input wire logic [7:0] acc_out,
  input wire logic [7:0] b_out,
  input wire logic carry_out,
  input wire logic nibble_carry_out,
  input wire logic signed_wrap_out,
  input wire logic [15:0] pc_out,
  input wire logic pc_load_out,
  input wire logic latch_read_out
);
  default clocking dc @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  logic [15:0] tgt;
  logic [2:0] flg;
  // Branch target as seen at the take edge
  assign tgt = pc_in + 16'h0003 +
    ((acc_out != operand1_in) ? {{8{operand2_in[7]}}, operand2_in} : 16'h0000);
  assign flg = {carry_out, nibble_carry_out, signed_wrap_out};
  sequence s_take(logic [7:0] op);
    op_valid_in && op_ready_out && opcode_in == op;
  endsequence
  sequence s_kept;
    flg == $past(flg, 2);
  endsequence
  a_cmp_cycles: assert property (s_take(OP_CMP_IMM) |=> !op_ready_out [*3] ##1 op_ready_out)
    else $error("compare busy time wrong");
  a_cmp_branch: assert property (s_take(OP_CMP_IMM) |-> ##2 pc_load_out && pc_out == $past(tgt, 2))
    else $error("compare branch target wrong");
  a_cmp_carry: assert property (s_take(OP_CMP_IMM) |-> ##4
    carry_out == ($past(acc_out, 4) < $past(operand1_in, 4)) && acc_out == $past(acc_out, 4))
    else $error("compare carry or operand wrong");
  a_zero_acc: assert property (s_take(OP_ZERO_A) |-> ##2 acc_out == 8'h00 ##0 s_kept)
    else $error("accumulator clear wrong");
  a_inv_acc: assert property (s_take(OP_INV_A) |-> ##2 acc_out == ~$past(acc_out, 2) ##0 s_kept)
    else $error("accumulator invert wrong");
  a_zero_carry: assert property (s_take(OP_ZERO_C) |-> ##2 !carry_out
    && nibble_carry_out == $past(nibble_carry_out, 2)
    && signed_wrap_out == $past(signed_wrap_out, 2))
    else $error("carry clear wrong");
  a_inv_carry: assert property (s_take(OP_INV_C) |-> ##2 carry_out != $past(carry_out, 2))
    else $error("carry toggle wrong");
  a_latch_read: assert property ((s_take(OP_INV_BIT) or s_take(OP_DEC_DIR)) |=> latch_read_out)
    else $error("port latch not selected");
  a_dec_acc: assert property (s_take(OP_DEC_A) |-> ##2 acc_out == $past(acc_out, 2) - 8'h01 ##0 s_kept)
    else $error("accumulator decrement wrong");
  a_div_zero: assert property (s_take(OP_DIV) ##0 b_out == 8'h00 |-> ##[3:20]
    op_ready_out && signed_wrap_out && !carry_out)
    else $error("divide by zero flags wrong");
endmodule // acb_alu_ops_chk

/* verif/acb_alu_ops_test.sv */
// Self-checking bench for the compare, clear, complement, adjust, decrement and divide unit
`timescale 1ns/1ps
module acb_alu_ops_test import acb_pkg::*;;
  logic clock_in = 1'b0, rst_b_in = 1'b0, op_valid_in = 1'b0, add_valid_in = 1'b0;
  logic add_with_carry_in = 1'b0, bit_rdata_in = 1'b0;
  logic [7:0] opcode_in = 8'h00, operand1_in = 8'h00, operand2_in = 8'h00, add_src_in = 8'h00;
  logic [7:0] mem_rdata_in = 8'h00, reg_rdata_in = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  logic op_ready_out, carry_out, nibble_carry_out, signed_wrap_out, pc_load_out, latch_read_out;
  logic mem_we_out, reg_we_out, bit_we_out, bit_wdata_out, ptr_sel_out;
  logic [2:0] reg_sel_out;
  logic [7:0] acc_out, b_out, wdata_out, addr_out;
  logic [15:0] pc_out;
  logic [7:0] am = 8'h00, rel = 8'h00;
  logic cm = 1'b0, acm = 1'b0, ovm = 1'b0, rdy_q = 1'b1;
  logic [15:0] pcv = 16'h0000;
  logic [15:0] rq[$], wq[$], pq[$];
  int n_fail = 0, check_count = 0, cyc = 0;
  acb_alu_ops dut (.clock_in, .rst_b_in, .op_valid_in, .opcode_in, .operand1_in, .operand2_in,
    .mem_rdata_in, .reg_rdata_in, .bit_rdata_in, .add_valid_in, .add_src_in, .add_with_carry_in,
    .pc_in, .op_ready_out, .acc_out, .b_out, .carry_out, .nibble_carry_out, .signed_wrap_out,
    .pc_out, .pc_load_out, .reg_sel_out, .ptr_sel_out, .latch_read_out, .mem_we_out,
    .reg_we_out, .wdata_out, .bit_we_out, .bit_wdata_out, .addr_out);
  always #12.5 clock_in = ~clock_in;
  task final_report();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic take(ref logic [15:0] q[$], input logic [15:0] got, input string what);
    if (q.size() == 0) cmp(16'hFFFF, 16'h0000, what);
    else cmp(got, q.pop_front(), what);
  endtask
  function logic [15:0] st();
    return {5'h00, am, cm, acm, ovm};
  endfunction
  // Negedge sampling keeps the monitor clear of the launch edge
  always @(negedge clock_in) begin
    if (rst_b_in) begin
      if (op_ready_out && !rdy_q) take(rq, {5'h00, acc_out, carry_out, nibble_carry_out,
        signed_wrap_out}, "state");
      if (mem_we_out) take(wq, {addr_out, wdata_out}, "byte write");
      if (reg_we_out) take(wq, {5'h00, reg_sel_out, wdata_out}, "register write");
      if (bit_we_out) take(wq, {addr_out, 7'h00, bit_wdata_out}, "bit write");
      if (pc_load_out) take(pq, pc_out, "pc");
    end
    rdy_q = op_ready_out;
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  // One data value feeds every read source, held through the execute edge
  task op(input logic [7:0] opc, input logic [7:0] o1, input logic [7:0] md);
    int i;
    @(posedge clock_in);
    op_valid_in <= 1'b1;
    opcode_in <= opc;
    operand1_in <= o1;
    operand2_in <= rel;
    mem_rdata_in <= md;
    reg_rdata_in <= md;
    bit_rdata_in <= md[0];
    pc_in <= pcv;
    rq.push_back(st());
    @(posedge clock_in);
    op_valid_in <= 1'b0;
    i = 0;
    @(negedge clock_in);
    while (op_ready_out !== 1'b1 && i < 40) begin
      @(negedge clock_in);
      i++;
    end
    if (i == 40) cmp(16'h0001, 16'h0000, "ready wait");
  endtask
  task add(input logic [7:0] v, input logic wc);
    logic [8:0] s;
    s = {1'b0, am} + {1'b0, v} + {8'h00, wc & cm};
    acm = ({1'b0, am[3:0]} + {1'b0, v[3:0]} + {4'h0, wc & cm}) > 5'h0F;
    ovm = (am[7] == v[7]) && (s[7] != am[7]);
    cm = s[8];
    am = s[7:0];
    @(posedge clock_in);
    add_valid_in <= 1'b1;
    add_src_in <= v;
    add_with_carry_in <= wc;
    @(posedge clock_in);
    add_valid_in <= 1'b0;
  endtask
  task zero_a();
    am = 8'h00;
    op(OP_ZERO_A, 8'h00, 8'h00);
  endtask
  task set_c(input logic v);
    cm = 1'b0;
    op(OP_ZERO_C, 8'h00, 8'h00);
    cm = v;
    if (v) op(OP_INV_C, 8'h00, 8'h00);
  endtask
  initial begin
    int k, dv;
    logic [7:0] d, s, x, y;
    logic [15:0] e;
    k = $urandom(62239);
    repeat (10) @(posedge clock_in);
    rst_b_in <= 1'b1;
    add(8'($urandom), 1'b0);
    zero_a();
    add(8'($urandom), 1'b1);
    am = ~am;
    op(OP_INV_A, 8'h00, 8'h00);
    set_c(1'b1);
    cm = 1'b0;
    op(OP_INV_C, 8'h00, 8'h00);
    x = 8'($urandom);
    wq.push_back({x, 8'h00});
    op(OP_ZERO_BIT, x, 8'hFF);
    d = 8'($urandom);
    wq.push_back({8'h90, 7'h00, ~d[0]});
    op(OP_INV_BIT, 8'h90, d);
    $display("test clear_invert done");
    for (k = 0; k < 8; k++) begin
      x = (k == 7) ? 8'h99 : {4'($urandom % 10), 4'($urandom % 10)};
      y = (k == 7) ? 8'h99 : {4'($urandom % 10), 4'($urandom % 10)};
      zero_a();
      add(x, 1'b0);
      set_c(k[0]);
      add(y, 1'b1);
      dv = x[7:4] * 10 + x[3:0] + y[7:4] * 10 + y[3:0] + k[0];
      am = {4'(dv % 100 / 10), 4'(dv % 10)};
      cm = cm | (dv > 99);
      op(OP_BCD_ADJ, 8'h00, 8'h00);
    end
    $display("test bcd_adjust done");
    for (k = 0; k < 8; k++) begin
      d = 8'($urandom);
      s = (k > 3) ? d : 8'($urandom);
      x = 8'($urandom);
      zero_a();
      add(d, 1'b0);
      rel = 8'($urandom);
      pcv = 16'($urandom);
      pq.push_back(pcv + 16'h0003 + ((d != s) ? {{8{rel[7]}}, rel} : 16'h0000));
      cm = d < s;
      case (k % 4)
        0: op(OP_CMP_DIR, x, s);
        1: op(OP_CMP_IMM, s, x);
        2: op({OP_CMP_REG, x[2:0]}, s, d);
        default: op({OP_CMP_IND, x[0]}, s, d);
      endcase
    end
    $display("test compare done");
    zero_a();
    am = 8'hFF;
    op(OP_DEC_A, 8'h00, 8'h00);
    for (k = 0; k < 6; k++) begin
      d = (k == 0) ? 8'h00 : 8'($urandom);
      x = 8'($urandom);
      e = {((k % 3 == 1) ? x : 8'h00), d - 8'h01};
      if (k % 3 == 0) e[15:8] = {5'h00, x[2:0]};
      wq.push_back(e);
      case (k % 3)
        0: op({OP_DEC_REG, x[2:0]}, 8'h00, d);
        1: op(OP_DEC_DIR, x, d);
        default: op({OP_DEC_IND, x[0]}, 8'h00, d);
      endcase
      if (k % 3 == 2) cmp({15'h0000, ptr_sel_out}, {15'h0000, x[0]}, "pointer select");
    end
    $display("test decrement done");
    set_c(1'b1);
    cm = 1'b0;
    ovm = 1'b1;
    op(OP_DIV, 8'h00, 8'h00);
    repeat (2) @(posedge clock_in);
    cmp({8'h00, b_out}, 16'h0000, "b kept");
    cmp(16'(rq.size() + wq.size() + pq.size()), 16'h0000, "unconsumed");
    $display("test divide done");
    final_report();
  end
endmodule // acb_alu_ops_test
bind acb_alu_ops acb_alu_ops_chk u_chk (.clock_in, .rst_b_in, .op_valid_in, .opcode_in,
  .operand1_in, .operand2_in, .pc_in, .op_ready_out, .acc_out, .b_out, .carry_out,
  .nibble_carry_out, .signed_wrap_out, .pc_out, .pc_load_out, .latch_read_out);
